// [design/pin_sync.sv]
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins in and synchronised levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync width must be at least one");
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = pin_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_out = s_r.stable;
endmodule
`default_nettype wire

// [design/sensor_map.svh]
// Contract
// - reset pin restores all configuration defaults
// - output-disable pin high floats pixel outputs
// - standby pin low enters low-power standby
// - each snapshot request outputs exactly one frame
// - bulb exposure ends on snapshot request release
// - select pin picks one of two slave ids
// - pixel is one twelve-bit word, msb high
// - frame flag high over rows, low vblank
// - row flag high only during active pixels; the code also raises it on shown dark rows
// - flash high while all pixels expose together
// - array is 2752 columns by 2004 rows
// - default window is central 2592 by 1944
// - dark and active column/row ranges fixed
// - first output pixel is column 16, row 54
// - first row green-red, second blue-green
// - both greens kept as separate channels
// - progressive rows with horizontal and vertical blanking
// - dark rows read if shown or auto black
// - binning chooses dark rows leaving exactly eight
// - row skip ignored for dark rows
// - no dark rows otherwise, frame time unchanged
// - pixel valid only when both flags high
// - shown dark rows lead frame, frame flag extended
`ifndef SENSOR_MAP_SVH
`define SENSOR_MAP_SVH
`define REG_CTRL 8'h00
`define REG_EXPOSE 8'h04
`define REG_STATUS 8'h08
`define REG_SLAVE_ID 8'h0c
`define CTRL_SHOW_DARK 0
`define CTRL_MANUAL_BLACK_LEVEL_MODE 1
`define CTRL_MODE_LSB 2
`define CTRL_BIN_LSB 4
`define CTRL_SKIP_LSB 6
`define CTRL_RESET 8'h00
`define EXPOSE_RESET 16'h0100
`define STAT_STANDBY 16
`define STAT_EXPOSING 17
`define STAT_IN_FRAME 18
`define STAT_DARK_READ 19
`define ARRAY_COLS 2752
`define ARRAY_ROWS 2004
`define DARK_COL_LAST_L 9
`define DARK_COL_FIRST_R 2618
`define DARK_ROW_LAST_T 49
`define DARK_ROW_FIRST_B 2002
`define ACTIVE_WIDTH 2592
`define ACTIVE_HEIGHT 1944
`define COL_START 16
`define ROW_START 54
`define DARK_ROW_END 50
`define DARK_ROWS_BINNED 8
`define HBLANK_PIX 450
`define VBLANK_ROWS 26
`define ID_SEL_HIGH 8'hba
`define ID_SEL_LOW 8'h90
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [design/sensor_pkg.sv]
`default_nettype none
package sensor_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXPOSE = 3'b010,
        ST_FRAME = 3'b100
    } state_t;
    typedef enum logic [1:0] {
        MODE_CONT = 2'b00,
        MODE_SNAP = 2'b01,
        MODE_BULB = 2'b10,
        MODE_BULB_ALT = 2'b11
    } snap_mode_t;
    typedef enum logic [1:0] {
        CLR_GR = 2'b00,
        CLR_R = 2'b01,
        CLR_B = 2'b10,
        CLR_GB = 2'b11
    } color_t;
    typedef struct packed {
        state_t st;
        logic [12:0] col;
        logic [11:0] row;
        logic [15:0] exp_cnt;
        logic mclk_d;
        logic trig_d;
        logic pixclk;
        logic fv;
        logic lv;
        logic flash;
        logic oe;
        logic [11:0] dout;
        logic [7:0] dev_id;
        logic [7:0] ctrl;
        logic [15:0] expose;
        logic [15:0] frames;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sensor_state_t;
endpackage
`default_nettype wire

// [design/sensor_readout.sv]
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none
`include "sensor_map.svh"
module sensor_readout
    import sensor_pkg::*;
#(
    parameter int WIDTH = `ACTIVE_WIDTH,
    parameter int HEIGHT = `ACTIVE_HEIGHT,
    parameter int HBLANK = `HBLANK_PIX,
    parameter int VBLANK = `VBLANK_ROWS
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control pins
    input wire logic master_input_clock,
    input wire logic sensor_reset_n,
    input wire logic output_disable,
    input wire logic standby_n,
    input wire logic snapshot_trigger,
    input wire logic slave_select_pin,
    // pixel port
    output logic pixclk_o,
    output logic [11:0] pix_data_o,
    output logic frame_active_flag,
    output logic row_active_flag,
    output logic flash_o,
    output logic out_en,
    output logic [7:0] two_wire_id,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam logic [12:0] LINE_LEN = 13'(WIDTH + HBLANK);
    localparam logic [12:0] PIX_END = 13'(WIDTH);
    localparam logic [11:0] DARK_N = 12'(`DARK_ROWS_BINNED);
    localparam logic [11:0] ACT_END = 12'(`DARK_ROWS_BINNED + HEIGHT);
    localparam logic [11:0] TOTAL_ROWS = 12'(HEIGHT + VBLANK);

    localparam sensor_state_t RESET_STATE = '{
        st: ST_IDLE,
        ctrl: `CTRL_RESET,
        expose: `EXPOSE_RESET,
        bresp: `RESP_OKAY,
        rresp: `RESP_OKAY,
        default: '0
    };

    // parameter and geometry checks
    if (WIDTH < 2 || HEIGHT < 2 || HBLANK < 1) begin : g_bad_size
        $error("window and blanking must be non-empty");
    end
    if (WIDTH + HBLANK > 8191 || HEIGHT + VBLANK > 4095) begin : g_bad_fit
        $error("line or frame too long for counters");
    end
    if (VBLANK <= `DARK_ROWS_BINNED) begin : g_bad_vblank
        $error("vertical blanking must exceed the dark rows");
    end
    if (`COL_START + WIDTH > `ARRAY_COLS
            || `ROW_START + HEIGHT > `ARRAY_ROWS) begin : g_bad_win
        $error("window exceeds pixel array");
    end
    if (`COL_START <= `DARK_COL_LAST_L
            || `COL_START + `ACTIVE_WIDTH > `DARK_COL_FIRST_R
            || `ROW_START <= `DARK_ROW_LAST_T
            || `ROW_START + `ACTIVE_HEIGHT > `DARK_ROW_FIRST_B)
            begin : g_bad_map
        $error("active image overlaps dark pixels");
    end

    sensor_state_t s_r;
    sensor_state_t s_nxt;

    logic [5:0] pins_s;
    logic mclk_s;
    logic rst_s;
    logic oe_pin_s;
    logic stby_s;
    logic trig_s;
    logic sel_s;
    logic tick;
    logic mclk_fall;
    logic trig_rise;
    snap_mode_t mode;
    logic show_dark;
    logic dark_read;
    logic in_dark;
    logic in_active;
    logic fv_now;
    logic lv_now;
    logic [1:0] row_bin;
    logic [1:0] row_skip;
    logic [11:0] row_addr;
    logic [12:0] col_addr;
    logic [31:0] status_word;

    pin_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({master_input_clock, sensor_reset_n, output_disable,
                 standby_n, snapshot_trigger, slave_select_pin}),
        .pin_out(pins_s)
    );

    assign {mclk_s, rst_s, oe_pin_s, stby_s, trig_s, sel_s} = pins_s;

    function automatic logic [31:0] merge_bytes(logic [31:0] old,
            logic [31:0] data, logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [11:0] dark_row(logic [2:0] idx,
            logic [1:0] bin);
        logic [11:0] step;
        step = {10'h000, bin} + 12'h001;
        return 12'(`DARK_ROW_END) - 12'(step * 12'h008)
            + 12'({9'h000, idx} * step);
    endfunction

    function automatic logic [11:0] active_row(logic [11:0] r,
            logic [1:0] skip);
        logic [11:0] step;
        step = {10'h000, skip} + 12'h001;
        return 12'(`ROW_START) + 12'({r[11:1], 1'b0} * step)
            + {11'h000, r[0]};
    endfunction

    function automatic logic [11:0] pix_word(logic [11:0] ra,
            logic [12:0] ca);
        color_t c;
        c = color_t'({ra[0], ca[0]});
        return {c, ra[4:0], ca[4:0]};
    endfunction

    assign tick = mclk_s & ~s_r.mclk_d;
    assign mclk_fall = ~mclk_s & s_r.mclk_d;
    assign trig_rise = trig_s & ~s_r.trig_d;
    assign mode = snap_mode_t'(s_r.ctrl[`CTRL_MODE_LSB +: 2]);
    assign row_bin = s_r.ctrl[`CTRL_BIN_LSB +: 2];
    assign row_skip = s_r.ctrl[`CTRL_SKIP_LSB +: 2];
    assign show_dark = s_r.ctrl[`CTRL_SHOW_DARK];
    assign dark_read = show_dark | ~s_r.ctrl[`CTRL_MANUAL_BLACK_LEVEL_MODE];
    assign in_dark = s_r.row < DARK_N;
    assign in_active = !in_dark && s_r.row < ACT_END;
    assign fv_now = (s_r.st == ST_FRAME)
        && (in_active || (in_dark && show_dark));
    assign lv_now = fv_now && s_r.col < PIX_END;
    assign col_addr = 13'(`COL_START) + s_r.col;
    // dark slot sits inside vertical blanking
    assign row_addr = in_dark
        ? dark_row(s_r.row[2:0], row_bin)
        : active_row(s_r.row - DARK_N, row_skip);

    assign status_word = {12'h000,
        dark_read,
        s_r.st == ST_FRAME,
        s_r.st == ST_EXPOSE,
        ~stby_s,
        s_r.frames};

    always_comb begin
        s_nxt = s_r;
        s_nxt.mclk_d = mclk_s;
        s_nxt.trig_d = trig_s;
        s_nxt.oe = ~oe_pin_s;
        s_nxt.dev_id = sel_s ? `ID_SEL_HIGH : `ID_SEL_LOW;

        // register writes
        if (awvalid && s_r.awready) begin
            s_nxt.aw_hold = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && s_r.wready) begin
            s_nxt.w_hold = 1'b1;
            s_nxt.wdata = wdata;
            s_nxt.wstrb = wstrb;
        end
        if (s_r.aw_hold && s_r.w_hold) begin
            s_nxt.aw_hold = 1'b0;
            s_nxt.w_hold = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `RESP_OKAY;
            if (s_r.aw_addr == `REG_CTRL) begin
                s_nxt.ctrl = 8'(merge_bytes({24'h000000, s_r.ctrl},
                    s_r.wdata, s_r.wstrb));
            end else if (s_r.aw_addr == `REG_EXPOSE) begin
                s_nxt.expose = 16'(merge_bytes({16'h0000, s_r.expose},
                    s_r.wdata, s_r.wstrb));
            end else if (s_r.aw_addr != `REG_STATUS
                    && s_r.aw_addr != `REG_SLAVE_ID) begin
                s_nxt.bresp = `RESP_SLVERR;
            end
        end else if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        s_nxt.awready = ~s_nxt.aw_hold & ~s_nxt.bvalid;
        s_nxt.wready = ~s_nxt.w_hold & ~s_nxt.bvalid;

        // register reads
        if (arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `RESP_OKAY;
            s_nxt.rdata = 32'h00000000;
            if (araddr == `REG_CTRL) begin
                s_nxt.rdata = {24'h000000, s_r.ctrl};
            end else if (araddr == `REG_EXPOSE) begin
                s_nxt.rdata = {16'h0000, s_r.expose};
            end else if (araddr == `REG_STATUS) begin
                s_nxt.rdata = status_word;
            end else if (araddr == `REG_SLAVE_ID) begin
                s_nxt.rdata = {24'h000000, s_r.dev_id};
            end else begin
                s_nxt.rresp = `RESP_SLVERR;
            end
        end else if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.arready = ~s_nxt.rvalid;

        // pixel clock low half
        if (mclk_fall) begin
            s_nxt.pixclk = 1'b0;
        end

        // frame sequencer
        unique case (s_r.st)
            ST_IDLE: begin
                s_nxt.col = 13'h0000;
                s_nxt.row = 12'h000;
                if (mode == MODE_CONT) begin
                    s_nxt.st = ST_FRAME;
                end else if (trig_rise) begin
                    s_nxt.st = ST_EXPOSE;
                    s_nxt.exp_cnt = s_r.expose;
                end
            end
            ST_EXPOSE: begin
                if (mode == MODE_SNAP) begin
                    if (tick) begin
                        if (s_r.exp_cnt == 16'h0000) begin
                            s_nxt.st = ST_FRAME;
                        end else begin
                            s_nxt.exp_cnt = s_r.exp_cnt - 16'h0001;
                        end
                    end
                end else if (!trig_s) begin
                    s_nxt.st = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (tick) begin
                    if (s_r.col == LINE_LEN - 13'h0001) begin
                        s_nxt.col = 13'h0000;
                        if (s_r.row == TOTAL_ROWS - 12'h001) begin
                            s_nxt.row = 12'h000;
                            s_nxt.frames = s_r.frames + 16'h0001;
                            if (mode != MODE_CONT) begin
                                s_nxt.st = ST_IDLE;
                            end
                        end else begin
                            s_nxt.row = s_r.row + 12'h001;
                        end
                    end else begin
                        s_nxt.col = s_r.col + 13'h0001;
                    end
                end
            end
        endcase

        // pixel outputs change on the pixel clock rise; flash follows the state each cycle
        if (tick) begin
            s_nxt.pixclk = 1'b1;
            s_nxt.fv = fv_now;
            s_nxt.lv = lv_now;
            s_nxt.dout = lv_now
                ? pix_word(row_addr, col_addr)
                : 12'h000;
        end
        s_nxt.flash = (s_nxt.st == ST_EXPOSE);

        // standby parks the sequencer with flags low
        if (!stby_s) begin
            s_nxt.st = ST_IDLE;
            s_nxt.col = 13'h0000;
            s_nxt.row = 12'h000;
            s_nxt.pixclk = 1'b0;
            s_nxt.fv = 1'b0;
            s_nxt.lv = 1'b0;
            s_nxt.flash = 1'b0;
            s_nxt.dout = 12'h000;
        end

        // sensor reset pin restores defaults
        if (!rst_s) begin
            s_nxt.st = ST_IDLE;
            s_nxt.col = 13'h0000;
            s_nxt.row = 12'h000;
            s_nxt.exp_cnt = 16'h0000;
            s_nxt.ctrl = `CTRL_RESET;
            s_nxt.expose = `EXPOSE_RESET;
            s_nxt.frames = 16'h0000;
            s_nxt.pixclk = 1'b0;
            s_nxt.fv = 1'b0;
            s_nxt.lv = 1'b0;
            s_nxt.flash = 1'b0;
            s_nxt.dout = 12'h000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= RESET_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pixclk_o = s_r.pixclk;
    assign pix_data_o = s_r.dout;
    assign frame_active_flag = s_r.fv;
    assign row_active_flag = s_r.lv;
    assign flash_o = s_r.flash;
    assign out_en = s_r.oe;
    assign two_wire_id = s_r.dev_id;
    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
endmodule
`default_nettype wire

// [test/pixel_capture.sv]
`default_nettype none
module pixel_capture (
    // pixel pins, sampled on clock fall
    input wire logic pixclk,
    input wire logic [11:0] pix,
    input wire logic fv,
    input wire logic lv,
    // capture control and results
    input wire logic clr,
    output logic [15:0] words,
    output logic [15:0] frames,
    output logic [11:0] cap [16]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fv_d;
    always @(negedge pixclk or posedge clr) begin
        if (clr) begin
            words <= 16'h0;
            frames <= 16'h0;
            fv_d <= 1'b0;
        end else begin
            fv_d <= fv;
            if (fv === 1'b1 && fv_d !== 1'b1) begin
                frames <= frames + 16'h1;
            end
            if (fv === 1'b1 && lv === 1'b1) begin
                if (words < 16'h10) begin
                    cap[words[3:0]] <= pix;
                end
                words <= words + 16'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [test/sensor_readout_assertions.sv]
`default_nettype none
`include "sensor_map.svh"
module sensor_readout_checker (
    // clock, reset and pins
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic master_input_clock,
    input wire logic sensor_reset_n,
    input wire logic output_disable,
    input wire logic standby_n,
    input wire logic slave_select_pin,
    // pixel port
    input wire logic pixclk_o,
    input wire logic [11:0] pix_data_o,
    input wire logic frame_active_flag,
    input wire logic row_active_flag,
    input wire logic flash_o,
    input wire logic out_en,
    input wire logic [7:0] two_wire_id,
    // read answer
    input wire logic rvalid,
    input wire logic [1:0] rresp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ok_r;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // cycles spent running out of reset and standby
    always_ff @(posedge aclk) begin
        if (!aresetn || !standby_n || !sensor_reset_n) begin
            ok_r <= 3'h0;
        end else if (ok_r != 3'h7) begin
            ok_r <= ok_r + 3'h1;
        end
    end
    AST_OUT_OFF: assert property (output_disable [*5] |-> !out_en)
        else $error("outputs driven while disabled");
    AST_ID: assert property (
        (ok_r == 3'h7 && $stable(slave_select_pin)) [*5]
        |-> two_wire_id == (slave_select_pin ? `ID_SEL_HIGH : `ID_SEL_LOW))
        else $error("two-wire id does not follow select pin");
    AST_STBY: assert property (
        (!standby_n) [*6]
        |-> !frame_active_flag && !row_active_flag && !flash_o)
        else $error("flags active in standby");
    AST_SRST: assert property (
        (!sensor_reset_n) [*6] |-> !frame_active_flag && !row_active_flag
        && !flash_o && !pixclk_o && pix_data_o == 12'h000)
        else $error("outputs active in sensor reset");
    AST_ROW_IN_FRAME: assert property (
        row_active_flag |-> frame_active_flag)
        else $error("row flag outside frame");
    AST_BLANK_ZERO: assert property (
        !row_active_flag |-> pix_data_o == 12'h000)
        else $error("data outside row");
    AST_COLOR: assert property (
        row_active_flag
        |-> pix_data_o[11:10] == {pix_data_o[5], pix_data_o[0]})
        else $error("colour code does not match position");
    AST_HOLD: assert property (
        pixclk_o && $past(pixclk_o)
        |-> $stable({pix_data_o, row_active_flag, frame_active_flag}))
        else $error("pixel word changed while clock high");
    AST_TICK: assert property (
        $rose(master_input_clock) && ok_r == 3'h7 |-> ##[1:4] pixclk_o)
        else $error("pixel clock missed a master tick");
    COV_FLASH: cover property (flash_o);
    COV_PIXEL: cover property (frame_active_flag && row_active_flag);
    COV_SLVERR: cover property (rvalid && rresp == `RESP_SLVERR);
endmodule
`default_nettype wire

// [test/tb_sensor_readout.sv]
`default_nettype none
`include "sensor_map.svh"
module tb_sensor_readout;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 8;
    localparam int H = 4;
    localparam int HB = 4;
    localparam int VB = 10;
    localparam int FRAME = (H + VB) * (W + HB) * 20;
    logic aclk, aresetn, mclk, srst_n, odis, stby_n, trig, ssel, clr;
    logic [7:0] awaddr, araddr, id;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, pclk, fv, lv, fl, oe;
    logic [1:0] bresp, rresp, r;
    logic [11:0] pix;
    logic [15:0] words, frames;
    logic [11:0] cap [16];
    int miscompares, n_tests;
    wire pclk_w = oe ? pclk : 1'bz;
    wire [11:0] pix_w = oe ? pix : 12'hzzz;
    wire fv_w = oe ? fv : 1'bz;
    wire lv_w = oe ? lv : 1'bz;
    sensor_readout #(.WIDTH(W), .HEIGHT(H), .HBLANK(HB), .VBLANK(VB))
    i_sensor_readout (
        .aclk(aclk), .aresetn(aresetn), .master_input_clock(mclk),
        .sensor_reset_n(srst_n), .output_disable(odis), .standby_n(stby_n),
        .snapshot_trigger(trig), .slave_select_pin(ssel), .pixclk_o(pclk),
        .pix_data_o(pix), .frame_active_flag(fv), .row_active_flag(lv),
        .flash_o(fl), .out_en(oe), .two_wire_id(id), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    pixel_capture i_pixel_capture (.pixclk(pclk_w), .pix(pix_w), .fv(fv_w),
        .lv(lv_w), .clr(clr), .words(words), .frames(frames), .cap(cap));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        mclk = 1'b0;
        #3;
        forever #80 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] e, input logic [31:0] g,
                       input string nm);
        n_tests++;
        if (e !== g) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // colour code, then low bits of row and column address
    function automatic logic [11:0] pw(input logic [1:0] c, input int r,
                                       input int k);
        return {c, 5'(r), 5'(k)};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int t;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        t = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            t++;
        end while (!bvalid && t < 40);
        r = bresp;
        bready <= 1'b0;
        chk(0, {31'h0, t >= 40}, "write wait");
    endtask
    task automatic rd(input logic [7:0] a);
        int t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            t++;
        end while (!rvalid && t < 40);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        chk(0, {31'h0, t >= 40}, "read wait");
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
        rd(a);
        chk(e, d, nm);
    endtask
    task automatic wfv(input logic v, output int c);
        c = 0;
        while (fv !== v && c < 4 * FRAME) begin
            @(posedge aclk);
            c++;
        end
        chk(0, {31'h0, c >= 4 * FRAME}, "frame flag wait");
    endtask
    task automatic clear();
        @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
    endtask
    task automatic collect(input int n);
        int c;
        c = 0;
        while (frames !== 16'h1 && c < 4 * FRAME) begin
            @(posedge aclk);
            c++;
        end
        wfv(1'b0, c);
        repeat (40) @(posedge aclk);
        chk(n, words, "valid words");
    endtask
    task automatic cfg(input logic [7:0] c, input int n);
        int a, b;
        wr(`REG_CTRL, {24'h0, c});
        wfv(1'b1, a);
        wfv(1'b0, a);
        wfv(1'b1, a);
        wfv(1'b0, b);
        chk(FRAME, a + b, "frame period");
        clear();
        collect(n);
    endtask
    task automatic shot(input logic [7:0] c, input int hold);
        wr(`REG_CTRL, {24'h0, c});
        clear();
        trig <= 1'b1;
        repeat (hold) @(posedge aclk);
        chk(1, fl, "flash");
        trig <= 1'b0;
        repeat (60) @(posedge aclk);
        chk(0, fl, "flash end");
        collect(W * H);
        repeat (3000) @(posedge aclk);
        chk(1, frames, "frames");
    endtask
    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge aclk);
        miscompares++;
        finish_test();
    end
    initial begin
        {aresetn, odis, trig, clr, awvalid, wvalid, bready} = '0;
        {arvalid, rready, awaddr, araddr, wdata} = '0;
        {srst_n, stby_n, ssel} = 3'b111;
        wstrb = 4'hf;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        rchk(`REG_CTRL, `CTRL_RESET, "ctrl");
        rchk(`REG_EXPOSE, `EXPOSE_RESET, "expose");
        rchk(`REG_SLAVE_ID, `ID_SEL_HIGH, "id reg");
        rchk(8'h10, 0, "unmapped data");
        chk(`RESP_SLVERR, r, "unmapped resp");
        wr(`REG_STATUS, 32'hffff_ffff);
        chk(`RESP_OKAY, r, "status write resp");
        cfg(8'h00, W * H);
        chk(pw(2'b00, `ROW_START, `COL_START), cap[0], "first word");
        chk(pw(2'b01, `ROW_START, `COL_START + 1), cap[1], "word 2");
        chk(pw(2'b10, `ROW_START + 1, `COL_START), cap[W], "row 2");
        chk(pw(2'b11, `ROW_START + 1, `COL_START + 1), cap[W + 1],
            "green blue");
        cfg(8'h02, W * H);
        chk(pw(2'b00, `ROW_START, `COL_START), cap[0], "first word");
        rd(`REG_STATUS);
        chk(0, d[`STAT_DARK_READ], "dark read");
        cfg(8'h03, W * (H + 8));
        cfg(8'hd3, W * (H + 8));
        chk(5'h02, cap[0][9:5], "dark row");
        chk(5'h04, cap[W][9:5], "dark row next");
        wr(`REG_EXPOSE, 32'h1);
        wr(`REG_CTRL, 32'h4);
        repeat (2 * FRAME) @(posedge aclk);
        shot(8'h04, 10);
        shot(8'h08, 400);
        shot(8'h0c, 400);
        odis <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(0, oe, "out_en");
        odis <= 1'b0;
        repeat (5) @(posedge aclk);
        chk(1, oe, "out_en");
        ssel <= 1'b0;
        repeat (5) @(posedge aclk);
        chk(`ID_SEL_LOW, id, "id pin");
        rchk(`REG_SLAVE_ID, `ID_SEL_LOW, "id reg");
        stby_n <= 1'b0;
        repeat (5) @(posedge aclk);
        rd(`REG_STATUS);
        chk(1, d[`STAT_STANDBY], "standby");
        chk(0, {fv, lv, fl}, "flags");
        stby_n <= 1'b1;
        srst_n <= 1'b0;
        repeat (5) @(posedge aclk);
        srst_n <= 1'b1;
        repeat (8) @(posedge aclk);
        rchk(`REG_CTRL, `CTRL_RESET, "ctrl");
        rchk(`REG_EXPOSE, `EXPOSE_RESET, "expose");
        finish_test();
    end
endmodule
bind sensor_readout sensor_readout_checker i_sensor_readout_checker (
    .aclk(aclk), .aresetn(aresetn), .master_input_clock(master_input_clock),
    .sensor_reset_n(sensor_reset_n), .output_disable(output_disable),
    .standby_n(standby_n), .slave_select_pin(slave_select_pin),
    .pixclk_o(pixclk_o), .pix_data_o(pix_data_o),
    .frame_active_flag(frame_active_flag),
    .row_active_flag(row_active_flag), .flash_o(flash_o), .out_en(out_en),
    .two_wire_id(two_wire_id), .rvalid(rvalid), .rresp(rresp));
`default_nettype wire
